/* File: risc_core_datapath.sv */
// Two-stage 8-bit RISC core: quadrature phasing, fetch pipeline, ALU, flags, core-mapped registers
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Separate program and data buses, 8-bit data
// - Each instruction is one 12-bit word
// - 12-bit program bus, one word per cycle
// - Fetch overlaps execute; single-cycle instructions
// - PC-changing instructions take two cycles
// - Four phases; PC++ phase one, latch phase four
// - PC, status, pointer mapped, direct and indirect
// - Any operation on any file location
// - 8-bit ALU: add, subtract, shift, logic
// - Arithmetic is two's complement
// - Two operands: W with file or literal
// - Single operand: W or a file location
// - W is 8-bit accumulator without address
// - ALU updates carry, nibble carry, zero
// - Subtract flags are inverted borrows
module risc_core_datapath
    import risc_core_pkg::*;
#(
    parameter int PC_W = PC_WIDTH
) (
    input  wire logic               clk,          // Core clock
    input  wire logic               rst_n,        // Async reset, active low
    output logic [PC_W-1:0]         prog_addr,    // Program memory word address
    input  wire logic [INSTR_W-1:0] prog_data,    // Program memory word
    output logic [FILE_AW-1:0]      file_addr,    // Data file address
    input  wire logic [DATA_W-1:0]  file_rd_data, // Data file read word
    output logic [DATA_W-1:0]       file_wr_data, // Data file write word
    output logic                    file_wr_en,   // Data file write strobe
    output logic                    phase_one,    // First quadrature phase
    output logic                    phase_two,    // Second quadrature phase
    output logic                    phase_three,  // Third quadrature phase
    output logic                    phase_four    // Fourth quadrature phase
);
    phase_type          phase;
    phase_type          next_phase;
    logic [PC_W-1:0]    pc;
    logic [INSTR_W-1:0] ir;
    logic               ir_valid;
    logic [DATA_W-1:0]  w;
    logic [DATA_W-1:0]  fsr;
    logic [2:0]         status;
    logic [DATA_W-1:0]  opnd;

    always_comb begin
        case (phase)
            PH_ONE:   next_phase = PH_TWO;
            PH_TWO:   next_phase = PH_THREE;
            PH_THREE: next_phase = PH_FOUR;
            PH_FOUR:  next_phase = PH_ONE;
            default:  next_phase = PH_ONE;
        endcase
    end

    assign phase_one   = (phase == PH_ONE);
    assign phase_two   = (phase == PH_TWO);
    assign phase_three = (phase == PH_THREE);
    assign phase_four  = (phase == PH_FOUR);

    // whole instruction decoded from one word
    wire                  is_file  = ~ir[11];
    wire                  is_lit   = (ir[11:10] == 2'b10);
    wire                  is_goto  = (ir[11:10] == 2'b11);
    // Code 15 has no enum name; fold it onto NOP so it can never write
    wire alu_op_type      file_op  = (ir[10:7] == 4'hF) ? ALU_NOP : alu_op_type'(ir[10:7]);
    wire                  dest_f   = ir[6];
    wire [FILE_AW-1:0]    f_field  = ir[5:0];
    wire [DATA_W-1:0]     literal  = ir[7:0];
    wire [1:0]            lit_sel  = ir[9:8];

    wire alu_op_type lit_op = (lit_sel == LIT_ADD) ? ALU_ADD :
                              (lit_sel == LIT_AND) ? ALU_AND :
                              (lit_sel == LIT_IOR) ? ALU_IOR : ALU_MOVF;
    wire alu_op_type alu_op = is_file ? file_op : (is_lit ? lit_op : ALU_NOP);

    // indirect through the pointer reaches every location; pointing at location 0 reads zero and writes nothing
    wire [FILE_AW-1:0] eff_addr = (f_field == IND_ADDR) ? fsr[FILE_AW-1:0] : f_field;

    // core registers answer inside the data map
    wire [DATA_W-1:0] read_data =
        (file_addr == IND_ADDR)    ? 8'h00 :
        (file_addr == PCL_ADDR)    ? pc[DATA_W-1:0] :
        (file_addr == STATUS_ADDR) ? {5'h00, status} :
        (file_addr == FSR_ADDR)    ? fsr : file_rd_data;

    wire core_loc = (file_addr == IND_ADDR) || (file_addr == PCL_ADDR) ||
                    (file_addr == STATUS_ADDR) || (file_addr == FSR_ADDR);

    // second operand is a file word or a literal
    wire [DATA_W-1:0] alu_b = is_lit ? literal : opnd;

    logic [DATA_W-1:0] alu_res;
    logic              alu_c;
    logic              alu_dc;
    logic              aff_c;
    logic              aff_dc;
    logic              aff_z;
    logic [4:0]        nib_sum;
    logic [DATA_W:0]   full_sum;

    always_comb begin
        nib_sum  = 5'h00;
        full_sum = 9'h000;
        alu_res  = alu_b;
        alu_c    = status[C_BIT];
        alu_dc   = status[DC_BIT];
        aff_c    = 1'b0;
        aff_dc   = 1'b0;
        aff_z    = 1'b1;
        case (alu_op)
            ALU_MOVF:  alu_res = alu_b;
            ALU_MOVWF: begin
                alu_res = w;
                aff_z   = 1'b0;
            end
            ALU_CLR:   alu_res = 8'h00;
            ALU_ADD: begin
                nib_sum  = {1'b0, alu_b[3:0]} + {1'b0, w[3:0]};
                full_sum = {1'b0, alu_b} + {1'b0, w};
                alu_res  = full_sum[DATA_W-1:0];
                alu_c    = full_sum[DATA_W];
                alu_dc   = nib_sum[4];
                aff_c    = 1'b1;
                aff_dc   = 1'b1;
            end
            // carry out of b + ~w + 1 is the inverted borrow
            ALU_SUB: begin
                nib_sum  = {1'b0, alu_b[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
                full_sum = {1'b0, alu_b} + {1'b0, ~w} + 9'h001;
                alu_res  = full_sum[DATA_W-1:0];
                alu_c    = full_sum[DATA_W];
                alu_dc   = nib_sum[4];
                aff_c    = 1'b1;
                aff_dc   = 1'b1;
            end
            ALU_AND:   alu_res = alu_b & w;
            ALU_IOR:   alu_res = alu_b | w;
            ALU_XOR:   alu_res = alu_b ^ w;
            ALU_COM:   alu_res = ~alu_b;
            ALU_INC:   alu_res = alu_b + 8'h01;
            ALU_DEC:   alu_res = alu_b - 8'h01;
            ALU_RRF: begin
                alu_res = {status[C_BIT], alu_b[7:1]};
                alu_c   = alu_b[0];
                aff_c   = 1'b1;
                aff_z   = 1'b0;
            end
            ALU_RLF: begin
                alu_res = {alu_b[6:0], status[C_BIT]};
                alu_c   = alu_b[7];
                aff_c   = 1'b1;
                aff_z   = 1'b0;
            end
            ALU_SWAP: begin
                alu_res = {alu_b[3:0], alu_b[7:4]};
                aff_z   = 1'b0;
            end
            default:   aff_z = 1'b0;
        endcase
    end

    // single-operand results go back to W or the file
    wire wr_file = ir_valid && is_file && alu_op != ALU_NOP && (dest_f || alu_op == ALU_MOVWF);
    wire wr_w    = ir_valid && ((is_file && !dest_f && alu_op != ALU_MOVWF && alu_op != ALU_NOP) || is_lit);
    wire wr_pcl    = wr_file && (file_addr == PCL_ADDR);
    wire wr_status = wr_file && (file_addr == STATUS_ADDR);
    wire wr_fsr    = wr_file && (file_addr == FSR_ADDR);
    wire wr_ext    = wr_file && !core_loc;
    wire branch    = ir_valid && (is_goto || wr_pcl);
    wire flag_we   = ir_valid && (is_file || is_lit) && !wr_status;

    // explicit status write beats flag update
    wire [2:0] next_status = wr_status ? alu_res[2:0] :
        {aff_z ? (alu_res == 8'h00) : status[Z_BIT],
         aff_dc ? alu_dc : status[DC_BIT],
         aff_c ? alu_c : status[C_BIT]};

    wire [PC_W-1:0] branch_target = is_goto ? ir[PC_W-1:0] : PC_W'(alu_res);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_ONE;
        end else begin
            phase <= next_phase;
        end
    end

    // PC steps in phase one, branches load it in phase four
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc        <= PC_RESET;
            prog_addr <= PC_RESET;
        end else if (phase_one) begin
            pc        <= PC_W'(pc + 1'b1);
            prog_addr <= pc;
        end else if (phase_four && branch) begin
            pc        <= branch_target;
        end
    end

    // next word latched while the current one executes
    // a branch discards the word already fetched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir       <= IR_RESET;
            ir_valid <= 1'b0;
        end else if (phase_four) begin
            ir       <= prog_data;
            ir_valid <= !branch;
        end
    end

    // data file accessed on its own bus
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            file_addr    <= IND_ADDR;
            opnd         <= 8'h00;
            file_wr_data <= 8'h00;
            file_wr_en   <= 1'b0;
        end else begin
            if (phase_one) begin
                file_addr <= eff_addr;
            end
            if (phase_two) begin
                opnd <= read_data;
            end
            if (phase_three) begin
                file_wr_data <= alu_res;
            end
            file_wr_en <= phase_three && wr_ext;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w      <= W_RESET;
            fsr    <= FSR_RESET;
            status <= STATUS_RESET;
        end else if (phase_four) begin
            if (wr_w) begin
                w <= alu_res;
            end
            if (wr_fsr) begin
                fsr <= alu_res;
            end
            if (flag_we || wr_status) begin
                status <= next_status;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_phase_walk;
        phase_two ##1 phase_three ##1 phase_four ##1 phase_one;
    endsequence

    property p_phase_rotate;
        phase_one |=> s_phase_walk;
    endproperty
    a_phase_rotate: assert property (p_phase_rotate) else $error("phase rotation broken");

    property p_pc_step;
        phase_one |=> pc == PC_W'($past(pc) + 1'b1);
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc did not step in phase one");

    property p_ir_hold;
        !phase_four |=> $stable(ir);
    endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("instruction changed outside phase four");

    property p_fetch_overlap;
        (phase_four && !branch) |=> ir_valid;
    endproperty
    a_fetch_overlap: assert property (p_fetch_overlap) else $error("fetched word not executed");

    property p_branch_flush;
        (phase_four && branch) |=> !ir_valid [*4];
    endproperty
    a_branch_flush: assert property (p_branch_flush) else $error("branch did not discard fetch");

    property p_add_carry;
        (alu_op == ALU_ADD) |-> ({alu_c, alu_res} == ({1'b0, alu_b} + {1'b0, w}));
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add result or carry wrong");

    property p_sub_borrow;
        (alu_op == ALU_SUB) |-> (alu_c == (alu_b >= w)) && (alu_dc == (alu_b[3:0] >= w[3:0]));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("subtract borrow flags wrong");

    property p_zero_flag;
        (phase_four && flag_we && aff_z) |=> status[Z_BIT] == ($past(alu_res) == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_w_hold;
        !phase_four |=> $stable(w);
    endproperty
    a_w_hold: assert property (p_w_hold) else $error("W changed outside phase four");

    property p_wr_phase;
        file_wr_en |-> phase_four && $past(phase_three);
    endproperty
    a_wr_phase: assert property (p_wr_phase) else $error("file write outside phase four");
endmodule

`default_nettype wire

/* File: risc_core_pkg.sv */
// Shared widths, file map, flag positions and types of the RISC core datapath
package risc_core_pkg;
    localparam int DATA_W   = 8;
    localparam int INSTR_W  = 12;
    localparam int PC_WIDTH = 10;
    localparam int FILE_AW  = 6;

    // Core-resident locations in the data file map
    localparam logic [FILE_AW-1:0] IND_ADDR    = 6'h00;
    localparam logic [FILE_AW-1:0] PCL_ADDR    = 6'h02;
    localparam logic [FILE_AW-1:0] STATUS_ADDR = 6'h03;
    localparam logic [FILE_AW-1:0] FSR_ADDR    = 6'h04;

    // Status flag positions
    localparam int C_BIT  = 0;
    localparam int DC_BIT = 1;
    localparam int Z_BIT  = 2;

    // Reset values
    localparam logic [2:0]          STATUS_RESET = 3'h0;
    localparam logic [DATA_W-1:0]   FSR_RESET    = 8'h00;
    localparam logic [DATA_W-1:0]   W_RESET      = 8'h00;
    localparam logic [INSTR_W-1:0]  IR_RESET     = 12'h000;
    localparam logic [PC_WIDTH-1:0] PC_RESET     = 10'h000;

    // Literal-class selector, instruction bits [9:8]
    localparam logic [1:0] LIT_MOV = 2'h0;
    localparam logic [1:0] LIT_ADD = 2'h1;
    localparam logic [1:0] LIT_AND = 2'h2;
    localparam logic [1:0] LIT_IOR = 2'h3;

    typedef enum logic [3:0] {
        ALU_MOVF, ALU_MOVWF, ALU_CLR, ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR,
        ALU_XOR, ALU_COM, ALU_INC, ALU_DEC, ALU_RRF, ALU_RLF, ALU_SWAP, ALU_NOP
    } alu_op_type;

    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} phase_type;
endpackage

/* File: risc_mem_model.sv */
// Behavioural program memory and data file seen by the core
`timescale 1ns/1ps
`default_nettype none
module risc_mem_model
    import risc_core_pkg::*;
(
    input  wire logic [PC_WIDTH-1:0] prog_addr,    // Program word address
    output logic [INSTR_W-1:0]       prog_data,    // Program word
    input  wire logic                clk,          // Core clock
    input  wire logic [FILE_AW-1:0]  file_addr,    // File address
    output logic [DATA_W-1:0]        file_rd_data, // File read word
    input  wire logic [DATA_W-1:0]   file_wr_data, // File write word
    input  wire logic                file_wr_en,   // File write strobe
    input  wire logic                phase_two,    // Read sample phase
    input  wire logic                phase_four    // Fetch latch phase
);
    logic [INSTR_W-1:0] prog [0:(1<<PC_WIDTH)-1];
    logic [DATA_W-1:0]  file_mem [0:(1<<FILE_AW)-1];
    // separate buses, whole word
    // Outside the valid phase the words are inverted so a late sample shows up
    assign prog_data    = phase_four ? prog[prog_addr] : ~prog[prog_addr];
    assign file_rd_data = phase_two ? file_mem[file_addr] : ~file_mem[file_addr];
    // Plain always: the bench preloads file_mem by hierarchical reference
    always @(posedge clk) begin
        if (file_wr_en) begin
            file_mem[file_addr] <= file_wr_data;
        end
    end
endmodule
`default_nettype wire

/* File: risc_core_datapath_test.sv */
// Self-checking bench for the RISC core datapath
`timescale 1ns/1ps
`default_nettype none
module risc_core_datapath_test
    import risc_core_pkg::*;
;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    logic [PC_WIDTH-1:0] prog_addr;
    logic [INSTR_W-1:0]  prog_data;
    logic [FILE_AW-1:0]  file_addr;
    logic [DATA_W-1:0]   file_rd_data;
    logic [DATA_W-1:0]   file_wr_data;
    logic                file_wr_en;
    logic                phase_one;
    logic                phase_two;
    logic                phase_three;
    logic                phase_four;
    int                  n_fail = 0;
    int                  check_count = 0;
    int                  cycles = 0;
    logic [7:0]          icyc = 8'h00;
    logic [1:0]          qc = 2'h0;
    logic [23:0]         wq[$];

    risc_core_datapath dut (.clk(clk), .rst_n(rst_n), .prog_addr(prog_addr), .prog_data(prog_data),
        .file_addr(file_addr), .file_rd_data(file_rd_data), .file_wr_data(file_wr_data),
        .file_wr_en(file_wr_en), .phase_one(phase_one), .phase_two(phase_two),
        .phase_three(phase_three), .phase_four(phase_four));
    risc_mem_model mem (.prog_addr(prog_addr), .prog_data(prog_data), .clk(clk), .file_addr(file_addr),
        .file_rd_data(file_rd_data), .file_wr_data(file_wr_data), .file_wr_en(file_wr_en),
        .phase_two(phase_two), .phase_four(phase_four));

    initial begin
        forever #2 clk = ~clk;
    end

    function automatic logic [11:0] fo(alu_op_type op, logic d, logic [5:0] a);
        return {1'b0, op, d, a};
    endfunction
    function automatic logic [11:0] lit(logic [1:0] s, logic [7:0] k);
        return {2'b10, s, k};
    endfunction

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Each write is logged as {instruction cycle, address, data}
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (!rst_n) begin
            icyc <= 8'h00;
            qc   <= 2'h0;
        end else begin
            check({20'h0, phase_one, phase_two, phase_three, phase_four}, 24'(4'h8 >> qc));
            qc <= qc + 2'h1;
            if (phase_four === 1'b1) begin
                icyc <= icyc + 8'h01;
            end
        end
        if (rst_n && file_wr_en === 1'b1) begin
            wq.push_back({icyc, 2'b00, file_addr, file_wr_data});
            check({23'h0, phase_four}, 24'h1);
        end
        if (cycles == 2000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic run(input logic [11:0] p[$]);
        @(negedge clk) rst_n = 1'b0;
        repeat (8) @(negedge clk);
        foreach (mem.prog[i]) mem.prog[i] = 12'h700;
        foreach (p[i]) mem.prog[i] = p[i];
        wq.delete();
        rst_n = 1'b1;
        repeat (104) @(negedge clk);
    endtask

    task automatic scen_arith();
        mem.file_mem[6'h20] = 8'h10;
        mem.file_mem[6'h21] = 8'h03;
        run('{lit(LIT_MOV, 8'h0F), lit(LIT_ADD, 8'h01), fo(ALU_MOVWF, 1, 6'h10), fo(ALU_MOVF, 0, STATUS_ADDR),
            fo(ALU_MOVWF, 1, 6'h11), fo(ALU_SUB, 0, 6'h20), fo(ALU_MOVWF, 1, 6'h12), fo(ALU_MOVF, 0, STATUS_ADDR),
            fo(ALU_MOVWF, 1, 6'h13), lit(LIT_AND, 8'h00), fo(ALU_MOVF, 0, STATUS_ADDR), fo(ALU_MOVWF, 1, 6'h14),
            fo(ALU_SUB, 0, 6'h21), fo(ALU_MOVWF, 1, 6'h15), fo(ALU_RLF, 1, 6'h21), fo(ALU_MOVF, 0, STATUS_ADDR),
            fo(ALU_MOVWF, 1, 6'h16), fo(ALU_COM, 0, 6'h21), fo(ALU_XOR, 0, 6'h21), fo(ALU_MOVWF, 1, 6'h17),
            fo(ALU_INC, 1, 6'h17), fo(ALU_DEC, 1, 6'h21)});
        check(24'(wq.size()), 24'd11);
        check(wq[0], 24'h031010);
        check(wq[1], 24'h051102);
        check(wq[2], 24'h07120E);
        check(wq[3], 24'h091301);
        check(wq[4], 24'h0C1405);
        check(wq[5], 24'h0E15FE);
        check(wq[6], 24'h0F2106);
        check(wq[7], 24'h111600);
        check(wq[8], 24'h1417FF);
        check(wq[9], 24'h151700);
        check(wq[10], 24'h162105);
    endtask

    task automatic scen_branch();
        run('{lit(LIT_MOV, 8'h33), 12'hC04, fo(ALU_MOVWF, 1, 6'h18), fo(ALU_MOVWF, 1, 6'h19),
            fo(ALU_MOVWF, 1, 6'h1A), fo(ALU_MOVWF, 1, 6'h1B), lit(LIT_MOV, 8'h0A), fo(ALU_MOVWF, 1, PCL_ADDR),
            fo(ALU_MOVWF, 1, 6'h1C), fo(ALU_MOVWF, 1, 6'h1C), fo(ALU_MOVWF, 1, 6'h1D)});
        check(24'(wq.size()), 24'd3);
        check(wq[0], 24'h041A33);
        check(wq[1], 24'h051B33);
        check(wq[2], 24'h091D0A);
    endtask

    task automatic scen_indirect();
        mem.file_mem[FSR_ADDR] = 8'h77;
        run('{lit(LIT_MOV, 8'h22), fo(ALU_MOVWF, 1, FSR_ADDR), lit(LIT_MOV, 8'hA5), fo(ALU_MOVWF, 1, IND_ADDR),
            fo(ALU_MOVF, 0, IND_ADDR), lit(LIT_ADD, 8'h01), fo(ALU_MOVWF, 1, 6'h23), fo(ALU_MOVF, 0, FSR_ADDR),
            fo(ALU_MOVWF, 1, 6'h24)});
        check(24'(wq.size()), 24'd3);
        check(wq[0], 24'h0422A5);
        check(wq[1], 24'h0723A6);
        check(wq[2], 24'h092422);
    endtask

    initial begin
        scen_arith();
        scen_branch();
        scen_indirect();
        final_report();
    end
endmodule
`default_nettype wire
